// >>> i2c_slave_pkg.sv
package i2c_slave_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_ADDR = 8'h04;
    localparam logic [7:0] OFF_STAT = 8'h08;
    localparam logic [7:0] OFF_CLR_RD = 8'h0C;
    localparam logic [7:0] OFF_CLR_WR = 8'h10;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
    localparam logic [7:0] OFF_BUF = 8'h1C;
    localparam logic [7:0] OFF_TX = 8'h20;
    localparam logic [7:0] OFF_RX = 8'h24;
    localparam logic [7:0] OFF_COUNT = 8'h28;
    localparam logic [7:0] OFF_PWR = 8'h2C;
    // control register fields
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_WAKE_EN = 1;
    localparam int CTRL_SLEEP = 2;
    localparam int CTRL_MASTER_EN = 3;
    localparam int CTRL_RDBUF_OK = 4;
    localparam int CTRL_WRBUF_OK = 5;
    localparam int CTRL_INT_EN = 6;
    localparam int CTRL_W = 7;
    localparam logic [6:0] CTRL_RESET = 7'h00;
    localparam logic [6:0] ADDR_RESET = 7'h08;
    // slave flag fields, read flags in [2:0], write flags in [5:3]
    localparam int FLAG_DONE = 0;
    localparam int FLAG_ACTIVE = 1;
    localparam int FLAG_OVERRUN = 2;
    localparam int WR_FLAG_POS = 3;
    // interrupt status fields
    localparam int IRQ_RD_DONE = 0;
    localparam int IRQ_WR_DONE = 1;
    localparam int IRQ_RD_OVF = 2;
    localparam int IRQ_WR_OVF = 3;
    localparam int IRQ_WAKE = 4;
    localparam int IRQ_W = 5;
    // power status fields
    localparam int PWR_ASLEEP = 0;
    localparam int PWR_MASTER = 1;
    localparam int PWR_BACKUP = 2;
    localparam int PWR_WAKE = 3;
    // byte sent when no transmit data is available
    localparam logic [7:0] IDLE_BYTE = 8'hFF;
    localparam logic [2:0] LAST_BIT = 3'h7;

    typedef enum {
        S_IDLE, S_ADDR, S_ADDR_DEC, S_HOLD, S_ADDR_ACK, S_WR_BIT, S_WR_DEC,
        S_WR_ACK, S_RD_BIT, S_RD_ACK, S_RD_ACKD, S_WAIT
    } state_e;
endpackage

// >>> i2c_slave_ctrl.sv
`timescale 1ns/1ns
// Notes on behaviour
// - stopping the interface releases a held bus and returns to idle.
// - read-done flag sets when the master NAKs a transmitted byte.
// - read-active flag sets on read addressing, clears when read-done sets.
// - read-overrun flag sets when master reads beyond available transmit bytes.
// - write-done flag sets on a Stop ending a write addressed here.
// - write-active flag sets on write addressing, clears when write-done sets.
// - a byte written past the buffer end is NAKed and flags write-overrun.
// - clear-read returns and clears read flags only; clear-write likewise.
// - own address is programmable 0..127; respond only on a match.
// - with wake enabled, sleep waits for the current own transaction.
// - with wake enabled, pending sleep NAKs every later own transaction.
// - while asleep with wake enabled, an address match raises wake.
// - entering sleep with wake enabled parks master, enables backup regulator.
// - leaving sleep restores master only if it was on, drops backup.
// - waking transaction stays stretched until sleep is left with the interrupt enabled.
// - without a transmit buffer every read byte is 0xFF.
// - own address held as a 7-bit value without the direction bit.
module i2c_slave_ctrl #(
    parameter int CNT_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic scl_oe,
    output logic sda_o,
    output logic sda_oe,
    output logic irq,
    output logic wake_event,
    output logic master_active,
    output logic backup_reg_en
);
    i2c_slave_pkg::state_e state;
    logic scl_m, scl_s, scl_q, sda_m, sda_s, sda_q;
    logic [2:0] bit_cnt;
    logic [7:0] shift, tx_shift, rx_data, tx_data;
    logic [6:0] ctrl, own_addr;
    logic [2:0] rd_flags, wr_flags;
    logic [i2c_slave_pkg::IRQ_W-1:0] irq_stat, irq_mask;
    logic [CNT_W-1:0] rd_size, wr_size, rd_count, wr_count;
    logic reading, engaged, asleep, saved_master;

    // pin synchronisers, then one more stage for edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {scl_m, scl_s, scl_q} <= 3'h7;
            {sda_m, sda_s, sda_q} <= 3'h7;
        end else begin
            {scl_m, scl_s, scl_q} <= {scl_i, scl_m, scl_s};
            {sda_m, sda_s, sda_q} <= {sda_i, sda_m, sda_s};
        end
    end

    // bus conditions
    wire scl_rise = scl_s & ~scl_q;
    wire scl_fall = ~scl_s & scl_q;
    wire start_cond = scl_s & scl_q & sda_q & ~sda_s;
    wire stop_cond = scl_s & scl_q & ~sda_q & sda_s;

    // control decode
    wire wake_en = ctrl[i2c_slave_pkg::CTRL_WAKE_EN];
    wire sleep_req = ctrl[i2c_slave_pkg::CTRL_SLEEP];
    wire rd_buf_ok = ctrl[i2c_slave_pkg::CTRL_RDBUF_OK];
    wire wr_buf_ok = ctrl[i2c_slave_pkg::CTRL_WRBUF_OK];
    wire int_en = ctrl[i2c_slave_pkg::CTRL_INT_EN];
    wire run = ctrl[i2c_slave_pkg::CTRL_ENABLE] & ~(asleep & ~wake_en);

    // sleep sequencing
    wire in_idle = (state == i2c_slave_pkg::S_IDLE);
    wire enter_sleep = sleep_req & ~asleep & (~wake_en | (~engaged & in_idle));
    wire leave_sleep = ~sleep_req & asleep;
    wire nak_sleep = sleep_req & wake_en & ~asleep;
    wire resume = ~asleep & int_en;

    // address decision and per-byte events
    wire addr_hit = (shift[7:1] == own_addr);
    wire dec_fall = (state == i2c_slave_pkg::S_ADDR_DEC) & scl_fall;
    wire ack_addr = addr_hit & ~nak_sleep & (shift[0] | wr_buf_ok | asleep);
    wire ev_rd_start = dec_fall & ack_addr & shift[0];
    wire ev_wr_start = dec_fall & ack_addr & ~shift[0];
    wire ev_wake = dec_fall & ack_addr & asleep & wake_en;
    wire wr_full = (wr_count >= wr_size);
    wire wr_dec_fall = (state == i2c_slave_pkg::S_WR_DEC) & scl_fall;
    wire ev_wr_ovf = wr_dec_fall & wr_full;
    wire ev_wr_done = stop_cond & engaged & ~reading;
    wire ev_rd_done = (state == i2c_slave_pkg::S_RD_ACK) & scl_rise & sda_s;
    wire rd_over = (rd_count >= rd_size);
    wire ld_byte = scl_fall & (((state == i2c_slave_pkg::S_ADDR_ACK) & reading)
        | (state == i2c_slave_pkg::S_RD_ACKD));
    wire ev_rd_ovf = ld_byte & rd_buf_ok & rd_over;
    wire [7:0] next_byte = (~rd_buf_ok | rd_over) ? i2c_slave_pkg::IDLE_BYTE : tx_data;

    // protocol engine; stop and start win over any bit state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= i2c_slave_pkg::S_IDLE;
            bit_cnt <= 3'h0;
            shift <= 8'h00;
            tx_shift <= 8'h00;
            sda_oe <= 1'b0;
            scl_oe <= 1'b0;
            reading <= 1'b0;
            engaged <= 1'b0;
        end else if (!run) begin
            state <= i2c_slave_pkg::S_IDLE;
            sda_oe <= 1'b0;
            scl_oe <= 1'b0;
            engaged <= 1'b0;
        end else if (stop_cond) begin
            state <= i2c_slave_pkg::S_IDLE;
            sda_oe <= 1'b0;
            scl_oe <= 1'b0;
            engaged <= 1'b0;
        end else if (start_cond) begin
            state <= i2c_slave_pkg::S_ADDR;
            bit_cnt <= 3'h0;
            sda_oe <= 1'b0;
            engaged <= 1'b0;
        end else begin
            case (state)
                i2c_slave_pkg::S_ADDR, i2c_slave_pkg::S_WR_BIT: begin
                    if (scl_rise) begin
                        shift <= {shift[6:0], sda_s};
                        bit_cnt <= bit_cnt + 3'h1;
                        if (bit_cnt == i2c_slave_pkg::LAST_BIT) begin
                            state <= (state == i2c_slave_pkg::S_ADDR) ?
                                i2c_slave_pkg::S_ADDR_DEC : i2c_slave_pkg::S_WR_DEC;
                        end
                    end
                end
                i2c_slave_pkg::S_ADDR_DEC: begin
                    if (scl_fall) begin
                        if (ack_addr) begin
                            sda_oe <= 1'b1;
                            scl_oe <= asleep;
                            reading <= shift[0];
                            engaged <= 1'b1;
                            state <= asleep ? i2c_slave_pkg::S_HOLD : i2c_slave_pkg::S_ADDR_ACK;
                        end else begin
                            state <= i2c_slave_pkg::S_WAIT;
                        end
                    end
                end
                i2c_slave_pkg::S_HOLD: begin
                    if (resume) begin
                        scl_oe <= 1'b0;
                        state <= i2c_slave_pkg::S_ADDR_ACK;
                    end
                end
                i2c_slave_pkg::S_ADDR_ACK, i2c_slave_pkg::S_RD_ACKD: begin
                    if (scl_fall) begin
                        bit_cnt <= 3'h0;
                        if (ld_byte) begin
                            tx_shift <= next_byte;
                            sda_oe <= ~next_byte[7];
                            state <= i2c_slave_pkg::S_RD_BIT;
                        end else begin
                            sda_oe <= 1'b0;
                            state <= i2c_slave_pkg::S_WR_BIT;
                        end
                    end
                end
                i2c_slave_pkg::S_WR_DEC: begin
                    if (scl_fall) begin
                        sda_oe <= ~wr_full;
                        state <= wr_full ? i2c_slave_pkg::S_WAIT : i2c_slave_pkg::S_WR_ACK;
                    end
                end
                i2c_slave_pkg::S_WR_ACK: begin
                    if (scl_fall) begin
                        sda_oe <= 1'b0;
                        bit_cnt <= 3'h0;
                        state <= i2c_slave_pkg::S_WR_BIT;
                    end
                end
                i2c_slave_pkg::S_RD_BIT: begin
                    if (scl_fall) begin
                        if (bit_cnt == i2c_slave_pkg::LAST_BIT) begin
                            sda_oe <= 1'b0;
                            state <= i2c_slave_pkg::S_RD_ACK;
                        end else begin
                            tx_shift <= {tx_shift[6:0], 1'b0};
                            sda_oe <= ~tx_shift[6];
                            bit_cnt <= bit_cnt + 3'h1;
                        end
                    end
                end
                i2c_slave_pkg::S_RD_ACK: begin
                    if (scl_rise) begin
                        state <= sda_s ? i2c_slave_pkg::S_WAIT : i2c_slave_pkg::S_RD_ACKD;
                    end
                end
                default: begin
                    sda_oe <= 1'b0;
                end
            endcase
        end
    end

    // apb decode; the answer is registered with no wait state
    wire setup = psel & ~penable;
    wire acc_wr = psel & penable & pwrite & pready;
    wire acc_rd = psel & penable & ~pwrite & pready;
    wire sel_clr_rd = (paddr == i2c_slave_pkg::OFF_CLR_RD);
    wire sel_clr_wr = (paddr == i2c_slave_pkg::OFF_CLR_WR);
    wire sel_irq = (paddr == i2c_slave_pkg::OFF_IRQ_STAT);
    wire clr_rd = acc_rd & sel_clr_rd;
    wire clr_wr = acc_rd & sel_clr_wr;
    wire clr_irq = acc_rd & sel_irq;
    wire [3:0] pwr_view = {wake_event, backup_reg_en, master_active, asleep};
    wire mapped = (paddr[1:0] == 2'h0) && (paddr <= i2c_slave_pkg::OFF_PWR);
    logic [31:0] rdata;
    always_comb begin
        case (paddr)
            i2c_slave_pkg::OFF_CTRL: rdata = {25'h0, ctrl};
            i2c_slave_pkg::OFF_ADDR: rdata = {25'h0, own_addr};
            i2c_slave_pkg::OFF_STAT: rdata = {26'h0, wr_flags, rd_flags};
            i2c_slave_pkg::OFF_CLR_RD: rdata = {29'h0, rd_flags};
            i2c_slave_pkg::OFF_CLR_WR: rdata = {29'h0, wr_flags};
            i2c_slave_pkg::OFF_IRQ_STAT: rdata = {27'h0, irq_stat};
            i2c_slave_pkg::OFF_IRQ_MASK: rdata = {27'h0, irq_mask};
            i2c_slave_pkg::OFF_BUF: rdata = {16'h0, 8'(wr_size), 8'(rd_size)};
            i2c_slave_pkg::OFF_TX: rdata = {24'h0, tx_data};
            i2c_slave_pkg::OFF_RX: rdata = {24'h0, rx_data};
            i2c_slave_pkg::OFF_COUNT: rdata = {16'h0, 8'(wr_count), 8'(rd_count)};
            i2c_slave_pkg::OFF_PWR: rdata = {28'h0, pwr_view};
            default: rdata = 32'h0;
        endcase
    end

    // bus answer flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= setup;
            pslverr <= setup & ~mapped;
            prdata <= setup ? rdata : 32'h0;
        end
    end

    // software-written registers; a clear of the counts restarts both buffers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= i2c_slave_pkg::CTRL_RESET;
            own_addr <= i2c_slave_pkg::ADDR_RESET;
            irq_mask <= '0;
            rd_size <= '0;
            wr_size <= '0;
            tx_data <= 8'h00;
        end else if (acc_wr) begin
            case (paddr)
                i2c_slave_pkg::OFF_CTRL: ctrl <= pwdata[i2c_slave_pkg::CTRL_W-1:0];
                i2c_slave_pkg::OFF_ADDR: own_addr <= pwdata[6:0];
                i2c_slave_pkg::OFF_IRQ_MASK: irq_mask <= pwdata[i2c_slave_pkg::IRQ_W-1:0];
                i2c_slave_pkg::OFF_BUF: begin
                    rd_size <= CNT_W'(pwdata[7:0]);
                    wr_size <= CNT_W'(pwdata[15:8]);
                end
                i2c_slave_pkg::OFF_TX: tx_data <= pwdata[7:0];
                default: tx_data <= tx_data;
            endcase
        end
    end

    // buffer counters and received byte
    wire clr_cnt = acc_wr & (paddr == i2c_slave_pkg::OFF_COUNT);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_count <= '0;
            wr_count <= '0;
            rx_data <= 8'h00;
        end else begin
            if (clr_cnt) rd_count <= '0;
            else if (ld_byte & rd_buf_ok & ~rd_over) rd_count <= rd_count + 1'b1;
            if (clr_cnt) wr_count <= '0;
            else if (wr_dec_fall & ~wr_full) wr_count <= wr_count + 1'b1;
            if (wr_dec_fall & ~wr_full) rx_data <= shift;
        end
    end

    // sticky slave flags; a new event wins over the clear of returned bits
    wire [2:0] rd_set = {ev_rd_ovf, ev_rd_start, ev_rd_done};
    wire [2:0] wr_set = {ev_wr_ovf, ev_wr_start, ev_wr_done};
    wire [2:0] rd_drop = (clr_rd ? prdata[2:0] : 3'h0) | {1'b0, ev_rd_done, 1'b0};
    wire [2:0] wr_drop = (clr_wr ? prdata[2:0] : 3'h0) | {1'b0, ev_wr_done, 1'b0};
    wire [2:0] next_rd_flags = (rd_flags & ~rd_drop) | rd_set;
    wire [2:0] next_wr_flags = (wr_flags & ~wr_drop) | wr_set;
    wire [4:0] irq_ev = {ev_wake, ev_wr_ovf, ev_rd_ovf, ev_wr_done, ev_rd_done};
    wire [4:0] irq_drop = clr_irq ? prdata[4:0] : 5'h0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_flags <= 3'h0;
            wr_flags <= 3'h0;
            irq_stat <= '0;
            irq <= 1'b0;
        end else begin
            rd_flags <= next_rd_flags;
            wr_flags <= next_wr_flags;
            irq_stat <= (irq_stat & ~irq_drop) | irq_ev;
            irq <= |(irq_stat & irq_mask);
        end
    end

    // sleep state, master parking and backup regulator
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            asleep <= 1'b0;
            saved_master <= 1'b0;
            master_active <= 1'b0;
            backup_reg_en <= 1'b0;
            wake_event <= 1'b0;
        end else if (enter_sleep) begin
            asleep <= 1'b1;
            if (wake_en) begin
                saved_master <= master_active;
                master_active <= 1'b0;
                backup_reg_en <= 1'b1;
            end
        end else if (leave_sleep) begin
            asleep <= 1'b0;
            wake_event <= 1'b0;
            if (wake_en) begin
                master_active <= saved_master;
                backup_reg_en <= 1'b0;
            end
        end else begin
            if (ev_wake) wake_event <= 1'b1;
            if (!asleep) master_active <= ctrl[i2c_slave_pkg::CTRL_MASTER_EN];
        end
    end

    // open-drain data values: only ever pulled low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_o <= 1'b0;
            sda_o <= 1'b0;
        end else begin
            scl_o <= 1'b0;
            sda_o <= 1'b0;
        end
    end

    // checks on the behaviour above
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_stop_idle: assert property (!run |=> in_idle && !sda_oe && !scl_oe)
        else $error("stopped interface did not release the bus");
    a_rd_done_set: assert property (ev_rd_done |=> rd_flags[0] && !rd_flags[1])
        else $error("read done did not set or busy did not clear");
    a_rd_busy_set: assert property (ev_rd_start |=> rd_flags[1] ##1 rd_flags[1])
        else $error("read busy not raised on read addressing");
    a_rd_ovf_byte: assert property (ev_rd_ovf |=> tx_shift == 8'hFF && rd_flags[2])
        else $error("read overrun not flagged");
    a_wr_done_set: assert property (ev_wr_done |=> wr_flags[0] && !wr_flags[1])
        else $error("write done did not set or busy did not clear");
    a_wr_busy_set: assert property (ev_wr_start |=> wr_flags[1])
        else $error("write busy not raised on write addressing");
    a_wr_ovf_nak: assert property (ev_wr_ovf |=> !sda_oe && wr_flags[2])
        else $error("overflowing write byte not NAKed");
    a_clr_rd_only: assert property ((clr_rd && !(|wr_set)) |=> $stable(wr_flags))
        else $error("read clear disturbed write flags");
    a_addr_miss: assert property ((dec_fall && !addr_hit) |=> !sda_oe [*2])
        else $error("acknowledged a foreign address");
    a_sleep_waits: assert property ((nak_sleep && engaged) |=> !asleep)
        else $error("sleep entered during own transaction");
    a_sleep_nak: assert property ((dec_fall && nak_sleep) |=> !sda_oe)
        else $error("pending sleep did not NAK");
    a_wake_hold: assert property (ev_wake |=> wake_event && scl_oe)
        else $error("address match while asleep did not wake and stretch");
    a_save_state: assert property ((enter_sleep && wake_en) |=> !master_active && backup_reg_en)
        else $error("sleep entry did not park master");
    a_restore: assert property ((leave_sleep && wake_en) |=> master_active == $past(saved_master)
        && !backup_reg_en)
        else $error("wake did not restore master state");
    a_idle_byte: assert property ((ld_byte && !rd_buf_ok) |=> tx_shift == 8'hFF)
        else $error("missing read buffer did not give 0xFF");
    a_flag_sticky: assert property ((wr_flags[2] && !clr_wr) |=> wr_flags[2])
        else $error("sticky flag dropped without clear");

    c_read_done: cover property (ev_rd_done);
    c_write_done: cover property (ev_wr_done);
    c_wake: cover property (ev_wake ##[1:1000] (state == i2c_slave_pkg::S_ADDR_ACK));
    c_wr_overflow: cover property (ev_wr_ovf);
endmodule

// >>> i2c_bus_master.sv
`timescale 1ns/1ns
// bus master on the far side; a pull output high drives that line low
module i2c_bus_master (
    input wire logic scl,
    input wire logic sda,
    output logic scl_pull,
    output logic sda_pull
);
    localparam int HALF = 400;
    // both lines released while the bus is idle
    initial begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
    end
    // release the clock and wait out any stretching by the slave
    task automatic rise();
        scl_pull = 1'b0;
        wait (scl === 1'b1);
        #HALF;
    endtask
    task automatic fall();
        scl_pull = 1'b1;
        #(HALF / 2);
    endtask
    // start or repeated start: data falls while the clock is high
    task automatic start();
        sda_pull = 1'b0;
        #(HALF / 2);
        rise();
        sda_pull = 1'b1;
        #HALF;
        fall();
    endtask
    // stop: data rises while the clock is high, then the bus is free
    task automatic stop();
        sda_pull = 1'b1;
        #(HALF / 2);
        rise();
        sda_pull = 1'b0;
        #HALF;
    endtask
    // one bit out, the line sampled at the end of the high phase
    task automatic bit_io(input logic b, output logic r);
        sda_pull = ~b;
        #(HALF / 2);
        rise();
        r = sda;
        fall();
    endtask
    // eight bits msb first, then the acknowledge slot
    task automatic xfer(input logic [7:0] d, input logic ack_out, output logic [7:0] q,
                        output logic ack_in);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], b);
            q[i] = b;
        end
        bit_io(ack_out, ack_in);
    endtask
endmodule

// >>> tb.sv
`timescale 1ns/1ns
`define CHK(got, exp) begin \
    checked++; \
    if ((got) !== (exp)) begin \
        err_total++; \
        $display("ERROR %0t: got %0h expected %0h", $time, got, exp); \
    end \
end
module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, last_err, scl_pull, sda_pull;
    logic scl_o, scl_oe, sda_o, sda_oe, irq, wake_event, master_active, backup_reg_en;
    int err_total = 0;
    int checked = 0;
    // open-drain lines with pull-ups
    wire logic scl = ~(scl_oe | scl_pull);
    wire logic sda = ~(sda_oe | sda_pull);
    always #50 pclk = ~pclk;
    i2c_slave_ctrl u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .scl_i(scl), .sda_i(sda), .scl_o, .scl_oe, .sda_o,
        .sda_oe, .irq, .wake_event, .master_active, .backup_reg_en);
    i2c_bus_master u_mst (.scl(scl), .sda(sda), .scl_pull, .sda_pull);
    // one bus transfer: setup, then access held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        q = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask
    task automatic expect_reg(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        `CHK(q, e)
    endtask
    task automatic chk_irq(input logic e);
        repeat (3) @(posedge pclk);
        `CHK(irq, e)
    endtask
    // one byte on the link, echoed or returned data and acknowledge compared
    task automatic i2c(input logic [7:0] d, input logic ack_out, input logic [7:0] e,
                       input logic ack_e);
        logic [7:0] q;
        logic a;
        u_mst.xfer(d, ack_out, q, a);
        `CHK(q, e)
        `CHK(a, ack_e)
    endtask
    // write path, address match, overrun and interrupt handling
    task automatic t_write();
        expect_reg(i2c_slave_pkg::OFF_ADDR, 32'h08);
        expect_reg(8'h30, 32'h0);
        `CHK(last_err, 1'b1)
        wr(i2c_slave_pkg::OFF_ADDR, 32'h7F);
        wr(i2c_slave_pkg::OFF_BUF, 32'h0100);
        wr(i2c_slave_pkg::OFF_IRQ_MASK, 32'h02);
        wr(i2c_slave_pkg::OFF_CTRL, 32'h79);
        u_mst.start();
        i2c(8'h10, 1'b1, 8'h10, 1'b1);
        u_mst.stop();
        u_mst.start();
        i2c(8'hFE, 1'b1, 8'hFE, 1'b0);
        i2c(8'h3C, 1'b1, 8'h3C, 1'b0);
        expect_reg(i2c_slave_pkg::OFF_STAT, 32'h10);
        i2c(8'hC3, 1'b1, 8'hC3, 1'b1);
        u_mst.stop();
        expect_reg(i2c_slave_pkg::OFF_STAT, 32'h28);
        expect_reg(i2c_slave_pkg::OFF_RX, 32'h3C);
        chk_irq(1'b1);
        wr(i2c_slave_pkg::OFF_IRQ_MASK, 32'h0);
        chk_irq(1'b0);
        expect_reg(i2c_slave_pkg::OFF_IRQ_STAT, 32'h0A);
        wr(i2c_slave_pkg::OFF_IRQ_MASK, 32'h02);
        chk_irq(1'b0);
        $display("done write");
    endtask
    // read path, overrun, separate clears, idle byte without a buffer
    task automatic t_read();
        wr(i2c_slave_pkg::OFF_TX, 32'hA5);
        wr(i2c_slave_pkg::OFF_BUF, 32'h01);
        u_mst.start();
        i2c(8'hFF, 1'b1, 8'hFF, 1'b0);
        expect_reg(i2c_slave_pkg::OFF_STAT, 32'h2A);
        i2c(8'hFF, 1'b0, 8'hA5, 1'b0);
        i2c(8'hFF, 1'b1, 8'hFF, 1'b1);
        u_mst.stop();
        expect_reg(i2c_slave_pkg::OFF_STAT, 32'h2D);
        expect_reg(i2c_slave_pkg::OFF_CLR_RD, 32'h05);
        expect_reg(i2c_slave_pkg::OFF_STAT, 32'h28);
        expect_reg(i2c_slave_pkg::OFF_CLR_WR, 32'h05);
        wr(i2c_slave_pkg::OFF_CTRL, 32'h69);
        // counts restarted so an in-range byte would carry the transmit value
        wr(i2c_slave_pkg::OFF_COUNT, 32'h0);
        u_mst.start();
        i2c(8'hFF, 1'b1, 8'hFF, 1'b0);
        i2c(8'hFF, 1'b1, 8'hFF, 1'b1);
        u_mst.stop();
        expect_reg(i2c_slave_pkg::OFF_STAT, 32'h01);
        $display("done read");
    endtask
    // sleep requested mid-transaction, later traffic refused
    task automatic t_sleep();
        wr(i2c_slave_pkg::OFF_COUNT, 32'h0);
        wr(i2c_slave_pkg::OFF_BUF, 32'h0400);
        wr(i2c_slave_pkg::OFF_CTRL, 32'h7B);
        u_mst.start();
        i2c(8'hFE, 1'b1, 8'hFE, 1'b0);
        i2c(8'h11, 1'b1, 8'h11, 1'b0);
        wr(i2c_slave_pkg::OFF_CTRL, 32'h7F);
        expect_reg(i2c_slave_pkg::OFF_PWR, 32'h2);
        u_mst.start();
        i2c(8'hFE, 1'b1, 8'hFE, 1'b1);
        u_mst.stop();
        expect_reg(i2c_slave_pkg::OFF_PWR, 32'h5);
        `CHK(backup_reg_en, 1'b1)
        $display("done sleep");
    endtask
    // address match wakes, clock stays stretched until interrupts return
    task automatic t_wake();
        fork
            begin
                u_mst.start();
                i2c(8'hFE, 1'b1, 8'hFE, 1'b0);
                u_mst.stop();
            end
            begin
                while (wake_event !== 1'b1) begin
                    @(posedge pclk);
                end
                expect_reg(i2c_slave_pkg::OFF_PWR, 32'hD);
                repeat (20) @(posedge pclk);
                wr(i2c_slave_pkg::OFF_CTRL, 32'h3B);
                expect_reg(i2c_slave_pkg::OFF_PWR, 32'h2);
                `CHK({wake_event, master_active}, 2'b01)
                `CHK(scl_oe, 1'b1)
                wr(i2c_slave_pkg::OFF_CTRL, 32'h7B);
            end
        join
        `CHK(scl_oe, 1'b0)
        // write buffer ready but interface stopped: only the stop can refuse
        wr(i2c_slave_pkg::OFF_CTRL, 32'h20);
        u_mst.start();
        i2c(8'hFE, 1'b1, 8'hFE, 1'b1);
        u_mst.stop();
        `CHK(sda_oe, 1'b0)
        `CHK({scl_o, sda_o}, 2'b00)
        $display("done wake");
    endtask
    task automatic conclude();
        $display("checked %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // reset for five cycles, then the scenarios in turn
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_write();
        t_read();
        t_sleep();
        t_wake();
        conclude();
    end
    // watchdog against a hung handshake or a stuck clock stretch
    initial begin
        #3000000;
        err_total++;
        conclude();
    end
endmodule
